// ---- shared/dmst_pkg.sv ----
// Constants and carrier types for the delay-on-make switch timer
package dmst_pkg;
  localparam int SEL_W = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int TICK_W = 27;
  localparam logic [SEL_W-1:0] SEL_RST = 10'h000;
  localparam logic [SEL_W-1:0] CNT_RST = 10'h000;

  typedef enum logic [1:0] {
    DMST_IDLE = 2'b00,
    DMST_LOAD = 2'b01,
    DMST_TIME = 2'b11,
    DMST_DONE = 2'b10
  } dmst_state_t;

  typedef struct packed {
    logic load_on;
    logic timing;
    logic [SEL_W-1:0] delay_s;
    logic [SEL_W-1:0] elapsed_s;
  } dmst_status_t;
endpackage : dmst_pkg

// ---- hdl/dmst_tick.sv ----
// One-second timebase tick generator
`timescale 1ns/1ps
`default_nettype none
module dmst_tick #(
  parameter int TICK_CYC = 100_000_000,
  parameter int TICK_W = 27
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  wire wrap = (cnt_r == TICK_W'(TICK_CYC - 1));
  assign cnt_nxt = (!run || wrap) ? '0 : cnt_r + 1'b1;
  assign tick = run && wrap;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    tick |=> !tick) else $error("tick lasted two cycles");
endmodule : dmst_tick
`default_nettype wire

// ---- hdl/dmst_timer.sv ----
// Delay-on-make timer with ten binary-weighted selectors
`timescale 1ns/1ps
`default_nettype none
module dmst_timer #(
  parameter int TICK_CYC = dmst_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_in,
  input wire logic [dmst_pkg::SEL_W-1:0] sel_sw,
  output logic load_on,
  output dmst_pkg::dmst_status_t status
);
  import dmst_pkg::*;

  // Pins are asynchronous to sys_clk
  // Selector word is not debounced; a switch moved at power-up may be caught mid-change
  logic pwr_s1_r;
  logic pwr_s2_r;
  logic [SEL_W-1:0] sel_s1_r;
  logic [SEL_W-1:0] sel_s2_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      sel_s1_r <= SEL_RST;
      sel_s2_r <= SEL_RST;
    end else begin
      pwr_s1_r <= power_in;
      pwr_s2_r <= pwr_s1_r;
      sel_s1_r <= sel_sw;
      sel_s2_r <= sel_s1_r;
    end
  end

  dmst_state_t state_r;
  dmst_state_t state_nxt;
  logic [SEL_W-1:0] delay_r;
  logic [SEL_W-1:0] delay_nxt;
  logic [SEL_W-1:0] elapsed_r;
  logic [SEL_W-1:0] elapsed_nxt;
  logic load_r;
  logic load_nxt;
  logic tick;
  logic [SEL_W-1:0] sel_sum;
  logic timing_r;

  // Seconds carried by one selector position
  function automatic logic [SEL_W-1:0] sel_weight(input int pos);
    logic [SEL_W-1:0] w;
    w = '0;
    w[pos] = 1'b1;
    return w;
  endfunction : sel_weight

  // Sum kept explicit so another weighting only touches sel_weight
  logic [SEL_W:0][SEL_W-1:0] sel_acc;
  assign sel_acc[0] = '0;
  for (genvar gi = 0; gi < SEL_W; gi++) begin : g_weight
    wire logic [SEL_W-1:0] part = sel_s2_r[gi] ? sel_weight(gi) : '0;
    assign sel_acc[gi + 1] = sel_acc[gi] + part;
  end
  assign sel_sum = sel_acc[SEL_W];

  wire timing = (state_r == DMST_TIME);
  // An all-OFF word wraps the compare and times 1024 ticks
  wire expired = timing && tick && (elapsed_r + 1'b1 == delay_r);

  dmst_tick #(
    .TICK_CYC(TICK_CYC),
    .TICK_W(TICK_W)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(timing),
    .tick(tick)
  );

  // Power loss wins over every state; no other clear path exists
  always_comb begin
    state_nxt = state_r;
    delay_nxt = delay_r;
    elapsed_nxt = elapsed_r;
    load_nxt = load_r;
    if (!pwr_s2_r) begin
      state_nxt = DMST_IDLE;
      elapsed_nxt = CNT_RST;
      load_nxt = 1'b0;
    end else begin
      case (state_r)
        DMST_IDLE: begin
          state_nxt = DMST_LOAD;
        end
        DMST_LOAD: begin
          delay_nxt = sel_sum;
          elapsed_nxt = CNT_RST;
          state_nxt = DMST_TIME;
        end
        DMST_TIME: begin
          if (expired) begin
            load_nxt = 1'b1;
            state_nxt = DMST_DONE;
          end else if (tick) begin
            elapsed_nxt = elapsed_r + 1'b1;
          end
        end
        DMST_DONE: begin
          load_nxt = 1'b1;
        end
        default: begin
          state_nxt = DMST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= DMST_IDLE;
      delay_r <= SEL_RST;
      elapsed_r <= CNT_RST;
      load_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      delay_r <= delay_nxt;
      elapsed_r <= elapsed_nxt;
      load_r <= load_nxt;
    end
  end

  // Status flag comes straight from a flop, in step with the state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timing_r <= 1'b0;
    end else begin
      timing_r <= (state_nxt == DMST_TIME);
    end
  end

  assign load_on = load_r;
  assign status = '{load_on: load_r, timing: timing_r, delay_s: delay_r, elapsed_s: elapsed_r};

  // Helper: cycles since the timing state was entered
  logic [39:0] run_cyc_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_cyc_r <= '0;
    end else if (state_r == DMST_LOAD) begin
      run_cyc_r <= '0;
    end else if (timing) begin
      run_cyc_r <= run_cyc_r + 1'b1;
    end
  end

  sequence s_power_up;
    !pwr_s2_r ##1 pwr_s2_r;
  endsequence
  sequence s_start;
    state_r == DMST_IDLE ##1 state_r == DMST_LOAD ##1 timing;
  endsequence

  // Helper: ticks seen since the timing state was entered
  logic [SEL_W:0] tick_cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
    end else if (state_r == DMST_LOAD) begin
      tick_cnt_r <= '0;
    end else if (timing && tick) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  sequence s_last_tick;
    timing && tick && pwr_s2_r && elapsed_r + 1'b1 == delay_r;
  endsequence
  sequence s_latched;
    load_on && !timing && status.load_on;
  endsequence

  a_start_timing: assert property (@(posedge sys_clk) disable iff (rst)
    s_power_up |-> s_start) else $error("timing did not start on power up");
  a_off_while_timing: assert property (@(posedge sys_clk) disable iff (rst)
    timing |-> !load_on) else $error("load on during timing");
  a_on_at_expiry: assert property (@(posedge sys_clk) disable iff (rst)
    expired && pwr_s2_r |=> load_on && state_r == DMST_DONE) else $error("load not on at expiry");
  a_on_stays: assert property (@(posedge sys_clk) disable iff (rst)
    load_on && pwr_s2_r |=> load_on) else $error("load dropped with power present");
  a_loss_clears: assert property (@(posedge sys_clk) disable iff (rst)
    !pwr_s2_r |=> !load_on && elapsed_r == '0 && state_r == DMST_IDLE) else $error("power loss did not reset");
  a_delay_sampled: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == DMST_LOAD && pwr_s2_r |=> delay_r == $past(sel_s2_r)) else $error("delay not sampled");
  a_delay_held: assert property (@(posedge sys_clk) disable iff (rst)
    timing && $past(timing) |-> $stable(delay_r)) else $error("delay changed while timing");
  a_exact_length: assert property (@(posedge sys_clk) disable iff (rst)
    expired |-> run_cyc_r == 40'(delay_r) * 40'(TICK_CYC) - 40'd1) else $error("delay length wrong");
  a_count_bound: assert property (@(posedge sys_clk) disable iff (rst)
    timing && delay_r != '0 |-> elapsed_r < delay_r) else $error("elapsed passed delay");

  // Per-tick, latch, idle and selector-sum behaviour
  a_expiry_path: assert property (@(posedge sys_clk) disable iff (rst)
    s_last_tick |=> s_latched) else $error("last tick did not latch the load");
  a_no_early_load: assert property (@(posedge sys_clk) disable iff (rst)
    s_power_up |-> (!load_on) [*3]) else $error("load on right after power up");
  a_load_in_done: assert property (@(posedge sys_clk) disable iff (rst)
    load_on |-> state_r == DMST_DONE) else $error("load on outside done state");
  a_tick_step: assert property (@(posedge sys_clk) disable iff (rst)
    timing && tick && !expired && pwr_s2_r |=> elapsed_r == $past(elapsed_r) + 1'b1) else $error("tick did not step");
  a_no_step: assert property (@(posedge sys_clk) disable iff (rst)
    timing && !tick && pwr_s2_r |=> $stable(elapsed_r)) else $error("count moved without tick");
  a_tick_period: assert property (@(posedge sys_clk) disable iff (rst)
    tick |-> (run_cyc_r + 40'd1) % 40'(TICK_CYC) == 40'd0) else $error("tick off its period");
  a_tick_count: assert property (@(posedge sys_clk) disable iff (rst)
    timing |-> elapsed_r == tick_cnt_r[SEL_W-1:0]) else $error("elapsed differs from ticks");
  a_done_latched: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == DMST_DONE && pwr_s2_r |=> state_r == DMST_DONE && load_on) else $error("done state left");
  a_idle_cleared: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == DMST_IDLE |-> !load_on && elapsed_r == CNT_RST) else $error("idle not cleared");
  a_sum_binary: assert property (@(posedge sys_clk) disable iff (rst)
    sel_sum == sel_s2_r) else $error("selector weights not binary");
endmodule : dmst_timer
`default_nettype wire

// ---- verification/dmst_supply.sv ----
// Line supply model that keeps power off for a minimum time
`timescale 1ns/1ps
`default_nettype none
module dmst_supply #(
  parameter int OFF_MIN = 4
) (
  input wire logic sys_clk,
  input wire logic want_on,
  output logic power_in
);
  int off_cnt = 0;
  logic on_r = 1'b0;
  // Scaled stand-in for the minimum power-off time
  assign power_in = on_r;
  // Once applied, power stays on while want_on is held; re-applying waits out the off time
  always @(posedge sys_clk) begin
    on_r <= want_on && (on_r || off_cnt >= OFF_MIN);
    off_cnt <= on_r ? 0 : off_cnt + 1;
  end
endmodule : dmst_supply
`default_nettype wire

// ---- verification/tb_top.sv ----
// Random and corner-case bench for the switch timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dmst_pkg::*;
  localparam int T = 10;
  logic sys_clk = 0;
  logic rst = 1;
  logic want_on = 0;
  logic power_in;
  logic load_on;
  logic [SEL_W-1:0] sel_sw = 10'h001;
  dmst_status_t status;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] lf = 16'h0002;
  dmst_timer #(.TICK_CYC(T)) DUT (.sys_clk(sys_clk), .rst(rst), .power_in(power_in),
    .sel_sw(sel_sw), .load_on(load_on), .status(status));
  dmst_supply sup (.sys_clk(sys_clk), .want_on(want_on), .power_in(power_in));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic logic [SEL_W-1:0] exp_delay(input logic [SEL_W-1:0] s);
    int acc;
    acc = 0;
    for (int i = 0; i < SEL_W; i++) begin
      if (s[i]) begin
        acc += 1 << i;
      end
    end
    return SEL_W'(acc);
  endfunction : exp_delay
  task automatic chk(input logic [SEL_W-1:0] got, input logic [SEL_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc_n
  task automatic run(input logic [SEL_W-1:0] d);
    sel_sw = d;
    want_on = 1;
    cyc_n(6);
    // Late switch change must not move the delay
    sel_sw = ~d;
    chk(status.delay_s, exp_delay(d));
    chk({9'h000, status.timing}, 10'h001);
    cyc_n(int'(exp_delay(d)) * T - 6);
    chk({9'h000, load_on}, 10'h000);
    cyc_n(8);
    chk({9'h000, load_on}, 10'h001);
    chk({9'h000, status.load_on}, 10'h001);
    cyc_n(20);
    chk({9'h000, load_on}, 10'h001);
    want_on = 0;
    cyc_n(6);
    chk({9'h000, load_on}, 10'h000);
    chk(status.elapsed_s, 10'h000);
    $display("test delay %0d done", d);
  endtask : run
  // Generous ceiling over the longest expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    cyc_n(8);
    rst = 0;
    cyc_n(2);
    sel_sw = 10'h005;
    want_on = 1;
    cyc_n(30);
    chk(status.elapsed_s, 10'h002);
    chk({9'h000, status.timing}, 10'h001);
    want_on = 0;
    cyc_n(5);
    chk(status.elapsed_s, 10'h000);
    chk({9'h000, load_on}, 10'h000);
    $display("test power cut done");
    for (int i = 0; i < SEL_W; i++) begin
      run(10'h001 << i);
    end
    run(10'h3ff);
    repeat (4) begin
      lf = nxt(lf);
      run(lf[9:0] == 10'h000 ? 10'h001 : lf[9:0]);
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
